/* core/hbs_ctrl.v */
// Operation
// R1: frame bits 15..12 address, bit 10 half
// R2: fixed address map, thirteen unused
// R3: reg0: persist, status index, enables
// R4: persist clear: index used once, then zero
// R5: persist set: index kept until rewritten
// R6: index picks one of eight status words
// R7: enable bit zero tri-states channel output
// R8: reg1: supply, pump, watchdog, split, sides
// R9: supply enable gates pump and drive currents
// R10: pump switch connects switched pump output
// R11: watchdog timeout 25 ms or 500 ms
// R12: split select runs channel 7 split
// R13: side select picks high or low
// R14: reg2 upper bits zero, PWM per channel
// R15: source reg halves hold two-bit fields
// R16: host changes drive settings while disabled
// R17: host steps pre-charge code one at a time
// R18: source code picks PWM input one-four
// R19: reset clears every control bit
// R20: toggle bit flips each frame, watchdog
// R21: undefined command faults to safe state
// R22: bad address or half stores nothing
`timescale 1ns/1ps
`include "hbs_ctrl_map.vh"
module hbs_ctrl #(
  parameter WD_SHORT_CYC = `HBS_WD_SHORT_MS * `HBS_CLK_KHZ,
  parameter WD_LONG_CYC  = `HBS_WD_LONG_MS * `HBS_CLK_KHZ,
  parameter WD_W         = 25
) (
  input  wire                      clock_in,
  input  wire                      srst_in,
  input  wire                      sclk_in,
  input  wire                      csb_n_in,
  input  wire                      si_in,
  input  wire [3:0]                pwm_in,
  input  wire [8*`HBS_FRAME_W-1:0] status_words_in,
  output wire                      so_out,
  output wire                      so_oe_out,
  output reg  [`HBS_NCH-1:0]       channel_output_enable_out,
  output reg  [`HBS_NCH-1:0]       channel_drive_out,
  output reg  [`HBS_NCH-1:0]       channel_side_select_out,
  output reg  [`HBS_NCH-1:0]       channel_pwm_select_out,
  output reg  [13:0]               pwm_source_field_out,
  output reg                       drive_supply_enable_out,
  output reg                       pump_switch_enable_out,
  output reg                       watchdog_timeout_select_out,
  output reg                       channel7_split_select_out,
  output reg  [`HBS_IDX_W-1:0]     status_word_index_out,
  output reg                       serial_fault_out
);

  localparam [31:0]     WD_SHORT_M1   = WD_SHORT_CYC - 1;
  localparam [31:0]     WD_LONG_M1    = WD_LONG_CYC - 1;
  // counter width must cover the long timeout, upper bits cut on purpose
  localparam [WD_W-1:0] WD_SHORT_LAST = WD_SHORT_M1[WD_W-1:0];
  localparam [WD_W-1:0] WD_LONG_LAST  = WD_LONG_M1[WD_W-1:0];

  wire [5:0]              pins_s;
  wire [`HBS_FRAME_W-1:0] rx_word;
  wire [`HBS_FRAME_W-1:0] tx_word;
  wire                    frame;
  wire                    length_ok;

  reg                     persist_q;
  reg [`HBS_IDX_W-1:0]    idx_q;
  reg [`HBS_NCH-1:0]      oe_q;
  reg                     drive_supply_enable_q;
  reg                     pump_sw_q;
  reg                     wd_sel_q;
  reg                     split7_q;
  reg [`HBS_NCH-1:0]      side_q;
  reg [`HBS_NCH-1:0]      pwm_sel_q;
  reg [`HBS_SRC_LOW_W+`HBS_SRC_HIGH_W-1:0] src_q;
  reg                     toggle_exp_q;
  reg [WD_W-1:0]          wd_cnt_q;
  reg                     fault_q;

  hbs_sync #(
    .W     (6),
    .RESET (1'b0)
  ) u_sync_data (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .async_in ({pwm_in, si_in, sclk_in}),
    .sync_out (pins_s)
  );

  wire csb_n_s;

  hbs_sync #(
    .W     (1),
    .RESET (1'b1)
  ) u_sync_cs (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .async_in (csb_n_in),
    .sync_out (csb_n_s)
  );

  wire       sclk_s = pins_s[0];
  wire       si_s   = pins_s[1];
  wire [3:0] pwm_s  = pins_s[5:2];

  // word picked at chip select fall answers the previous command
  assign tx_word = status_words_in[{idx_q, 4'h0} +: `HBS_FRAME_W]; // R6

  hbs_spi_shift u_shift (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .sclk_in       (sclk_s),
    .csb_n_in      (csb_n_s),
    .si_in         (si_s),
    .tx_word_in    (tx_word),
    .frame_out     (frame),
    .length_ok_out (length_ok),
    .rx_word_out   (rx_word),
    .so_out        (so_out),
    .so_oe_out     (so_oe_out)
  );

  wire [3:0] addr   = rx_word[`HBS_ADDR_MSB:`HBS_ADDR_LSB]; // R1
  wire       ext    = rx_word[`HBS_EXT_BIT]; // R1
  wire       toggle = rx_word[`HBS_TOGGLE_BIT];

  // unused bits set, fixed half bit wrong, or unused address
  wire undef =
    (addr == `HBS_ADDR_UNUSED) | // R2 R22
    ((addr == `HBS_ADDR_PWMEN) & (rx_word[10:7] != 4'h0)) | // R14
    ((addr == `HBS_ADDR_PWMSRC) & ext &
     (rx_word[9:4] != 6'h00)) | // R15
    (((addr == `HBS_ADDR_DIAG) | (addr == `HBS_ADDR_DEGLITCH)) &
     ext); // R22

  wire frame_good = frame & length_ok & ~undef &
                    (toggle == toggle_exp_q); // R20
  wire frame_bad  = frame & ~frame_good; // R21

  wire [WD_W-1:0] wd_last = wd_sel_q ? WD_LONG_LAST : WD_SHORT_LAST; // R11
  wire            wd_expire = (wd_cnt_q == wd_last);

  always @(posedge clock_in) begin
    if (srst_in) begin
      toggle_exp_q <= 1'b0;
      wd_cnt_q     <= {WD_W{1'b0}};
      fault_q      <= 1'b0;
    end else begin
      if (frame_good)
        toggle_exp_q <= ~toggle_exp_q; // R20
      if (frame_good)
        wd_cnt_q <= {WD_W{1'b0}}; // R20
      else if (!wd_expire)
        wd_cnt_q <= wd_cnt_q + {{(WD_W-1){1'b0}}, 1'b1};
      // sticky until reset so a stray host cannot re-arm the bridge
      if (frame_bad | wd_expire)
        fault_q <= 1'b1; // R21 R20
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      persist_q <= `HBS_CTRL_RESET; // R19
      idx_q     <= `HBS_IDX_RESET; // R19
      oe_q      <= {`HBS_NCH{`HBS_CTRL_RESET}}; // R19
      drive_supply_enable_q  <= `HBS_CTRL_RESET; // R19
      pump_sw_q <= `HBS_CTRL_RESET; // R19
      wd_sel_q  <= `HBS_CTRL_RESET; // R19
      split7_q  <= `HBS_CTRL_RESET; // R19
      side_q    <= {`HBS_NCH{`HBS_CTRL_RESET}}; // R19
      pwm_sel_q <= {`HBS_NCH{`HBS_CTRL_RESET}}; // R19
      src_q     <= {(`HBS_SRC_LOW_W+`HBS_SRC_HIGH_W){1'b0}}; // R19
    end else if (frame) begin
      // a consumed read falls back to word zero
      if (!persist_q)
        idx_q <= `HBS_IDX_RESET; // R4
      if (frame_good) begin
        case (addr)
          `HBS_ADDR_READBACK: begin
            persist_q <= rx_word[`HBS_PERSIST_BIT]; // R3 R5
            idx_q     <= rx_word[`HBS_IDX_MSB:`HBS_IDX_LSB]; // R3
            oe_q      <= rx_word[`HBS_NCH-1:0]; // R3 R7
          end
          `HBS_ADDR_DRVMODE: begin
            drive_supply_enable_q  <= rx_word[`HBS_DRIVE_SUPPLY_ENABLE_BIT]; // R8
            pump_sw_q <= rx_word[`HBS_PUMP_SW_BIT]; // R8
            wd_sel_q  <= rx_word[`HBS_WD_SEL_BIT]; // R8
            split7_q  <= rx_word[`HBS_SPLIT7_BIT]; // R8
            side_q    <= rx_word[`HBS_NCH-1:0]; // R8
          end
          `HBS_ADDR_PWMEN: begin
            pwm_sel_q <= rx_word[`HBS_NCH-1:0]; // R14
          end
          `HBS_ADDR_PWMSRC: begin
            if (ext)
              src_q[13:10] <= rx_word[`HBS_SRC_HIGH_W-1:0]; // R15
            else
              src_q[9:0] <= rx_word[`HBS_SRC_LOW_W-1:0]; // R15
          end
          default: begin
          end
        endcase
      end
    end
  end

  // fault gates everything that can move a load
  always @(posedge clock_in) begin
    if (srst_in) begin
      channel_output_enable_out   <= {`HBS_NCH{1'b0}};
      channel_side_select_out     <= {`HBS_NCH{1'b0}};
      channel_pwm_select_out      <= {`HBS_NCH{1'b0}};
      pwm_source_field_out        <= 14'h0000;
      drive_supply_enable_out     <= 1'b0;
      pump_switch_enable_out      <= 1'b0;
      watchdog_timeout_select_out <= 1'b0;
      channel7_split_select_out   <= 1'b0;
      status_word_index_out       <= `HBS_IDX_RESET;
      serial_fault_out            <= 1'b0;
    end else begin
      channel_output_enable_out   <= oe_q & {`HBS_NCH{~fault_q}}; // R7 R21
      channel_side_select_out     <= side_q; // R13
      channel_pwm_select_out      <= pwm_sel_q; // R14
      pwm_source_field_out        <= src_q; // R15
      drive_supply_enable_out     <= drive_supply_enable_q & ~fault_q; // R9 R21
      pump_switch_enable_out      <= pump_sw_q & ~fault_q; // R10 R21
      watchdog_timeout_select_out <= wd_sel_q; // R11
      channel7_split_select_out   <= split7_q; // R12
      status_word_index_out       <= idx_q; // R6
      serial_fault_out            <= fault_q; // R20 R21
    end
  end

  // per channel: full on, or the routed PWM input
  genvar c;
  generate
    for (c = 0; c < `HBS_NCH; c = c + 1) begin : g_ch
      wire [1:0] src = src_q[2*c +: 2];
      wire       pwm_bit = pwm_s[src]; // R18
      always @(posedge clock_in) begin
        if (srst_in)
          channel_drive_out[c] <= 1'b0;
        else
          channel_drive_out[c] <= oe_q[c] & ~fault_q &
                                  (pwm_sel_q[c] ? pwm_bit : 1'b1); // R14
      end
    end
  endgenerate

endmodule // hbs_ctrl

/* core/hbs_ctrl_map.vh */
`ifndef HBS_CTRL_MAP_VH
`define HBS_CTRL_MAP_VH

// frame layout
`define HBS_FRAME_W       16
`define HBS_ADDR_MSB      15
`define HBS_ADDR_LSB      12
`define HBS_TOGGLE_BIT    11
`define HBS_EXT_BIT       10

// register addresses
`define HBS_ADDR_READBACK 4'h0
`define HBS_ADDR_DRVMODE  4'h1
`define HBS_ADDR_PWMEN    4'h2
`define HBS_ADDR_PWMSRC   4'h3
`define HBS_ADDR_DIAG     4'hc
`define HBS_ADDR_UNUSED   4'hd
`define HBS_ADDR_DEGLITCH 4'he

// readback_and_enable_reg fields
`define HBS_PERSIST_BIT   10
`define HBS_IDX_MSB       9
`define HBS_IDX_LSB       7
`define HBS_IDX_W         3
`define HBS_IDX_RESET     3'h0

// drive_mode_reg fields
`define HBS_DRIVE_SUPPLY_ENABLE_BIT    10
`define HBS_PUMP_SW_BIT   9
`define HBS_WD_SEL_BIT    8
`define HBS_SPLIT7_BIT    7

// pwm_source_reg fields
`define HBS_SRC_LOW_W     10
`define HBS_SRC_HIGH_W    4

// shared channel width and control reset value
`define HBS_NCH           7
`define HBS_CTRL_RESET    1'b0

// watchdog timing
`define HBS_CLK_KHZ       40000
`define HBS_WD_SHORT_MS   25
`define HBS_WD_LONG_MS    500

`endif

/* core/hbs_sync.v */
`timescale 1ns/1ps
module hbs_sync #(
  parameter       W      = 1,
  parameter [0:0] RESET  = 1'b0
) (
  input  wire         clock_in,
  input  wire         srst_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clock_in) begin
        if (srst_in) begin
          meta_q <= RESET;
          sync_q <= RESET;
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule // hbs_sync

/* core/hbs_spi_shift.v */
`timescale 1ns/1ps
`include "hbs_ctrl_map.vh"
module hbs_spi_shift (
  input  wire                   clock_in,
  input  wire                   srst_in,
  input  wire                   sclk_in,
  input  wire                   csb_n_in,
  input  wire                   si_in,
  input  wire [`HBS_FRAME_W-1:0] tx_word_in,
  output reg                    frame_out,
  output reg                    length_ok_out,
  output reg  [`HBS_FRAME_W-1:0] rx_word_out,
  output reg                    so_out,
  output reg                    so_oe_out
);

  reg                    sclk_d_q;
  reg                    csb_d_q;
  reg [`HBS_FRAME_W-1:0] sh_q;
  reg [3:0]              cnt_q;
  reg                    seen_q;

  wire rise   = sclk_in & ~sclk_d_q;
  wire fall   = ~sclk_in & sclk_d_q;
  wire cs_on  = ~csb_n_in & csb_d_q;
  wire cs_off = csb_n_in & ~csb_d_q;

  // one register serves both ways: what is shifted in pushes the
  // status word out, so longer daisy-chained frames pass through
  always @(posedge clock_in) begin
    if (srst_in) begin
      sclk_d_q      <= 1'b0;
      csb_d_q       <= 1'b1;
      sh_q          <= {`HBS_FRAME_W{1'b0}};
      cnt_q         <= 4'h0;
      seen_q        <= 1'b0;
      frame_out     <= 1'b0;
      length_ok_out <= 1'b0;
      rx_word_out   <= {`HBS_FRAME_W{1'b0}};
      so_out        <= 1'b0;
      so_oe_out     <= 1'b0;
    end else begin
      sclk_d_q  <= sclk_in;
      csb_d_q   <= csb_n_in;
      frame_out <= 1'b0;
      if (cs_on) begin
        sh_q      <= tx_word_in;
        cnt_q     <= 4'h0;
        seen_q    <= 1'b0;
        so_oe_out <= 1'b1;
        so_out    <= tx_word_in[`HBS_FRAME_W-1];
      end else if (cs_off) begin
        so_oe_out     <= 1'b0;
        frame_out     <= 1'b1;
        length_ok_out <= seen_q & (cnt_q == 4'h0);
        rx_word_out   <= sh_q;
      end else if (~csb_n_in) begin
        if (rise)
          so_out <= sh_q[`HBS_FRAME_W-1];
        if (fall) begin
          sh_q   <= {sh_q[`HBS_FRAME_W-2:0], si_in};
          cnt_q  <= cnt_q + 4'h1;
          seen_q <= 1'b1;
        end
      end
    end
  end

endmodule // hbs_spi_shift

/* bench/hbs_ctrl_monitor.sv */
`timescale 1ns/1ps
module hbs_ctrl_monitor (
  input wire logic        clock_in,
  input wire logic        srst_in,
  input wire logic        csb_n_in,
  input wire logic [3:0]  pwm_in,
  input wire logic        so_oe_out,
  input wire logic [6:0]  channel_output_enable_out,
  input wire logic [6:0]  channel_drive_out,
  input wire logic [6:0]  channel_side_select_out,
  input wire logic [6:0]  channel_pwm_select_out,
  input wire logic [13:0] pwm_source_field_out,
  input wire logic        drive_supply_enable_out,
  input wire logic        pump_switch_enable_out,
  input wire logic        watchdog_timeout_select_out,
  input wire logic        channel7_split_select_out,
  input wire logic [2:0]  status_word_index_out,
  input wire logic        serial_fault_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  chk_reset_clear: assert property ($fell(srst_in) |->
    !serial_fault_out && channel_output_enable_out == 7'h00 &&
    channel_side_select_out == 7'h00 && pwm_source_field_out == 14'h0000
    && !drive_supply_enable_out) else $error("reset left a setting");
  chk_fault_safe: assert property (serial_fault_out |->
    channel_output_enable_out == 7'h00 && !drive_supply_enable_out &&
    !pump_switch_enable_out) else $error("fault not safe");
  chk_fault_sticky: assert property (serial_fault_out |=>
    serial_fault_out) else $error("fault cleared");
  // guards tolerate one clock of lag between drive and its settings
  chk_off_no_drive: assert property ($stable(channel_output_enable_out) |->
    (channel_drive_out & ~channel_output_enable_out) == 7'h00)
    else $error("disabled channel driven");
  chk_full_on: assert property ($stable(channel_output_enable_out) &&
    $stable(channel_pwm_select_out) |-> (channel_output_enable_out &
    ~channel_pwm_select_out & ~channel_drive_out) == 7'h00)
    else $error("full-on channel not driven");
  chk_route_ch1: assert property (($stable(pwm_in)[*6]) ##0
    (channel_output_enable_out[0] && channel_pwm_select_out[0] &&
    $stable(pwm_source_field_out) && $stable(channel_pwm_select_out)) |->
    channel_drive_out[0] == pwm_in[pwm_source_field_out[1:0]])
    else $error("channel 1 pwm routing wrong");
  chk_cfg_idle: assert property (csb_n_in[*8] |->
    $stable(channel_side_select_out) && $stable(pwm_source_field_out) &&
    $stable(watchdog_timeout_select_out) &&
    $stable(channel7_split_select_out)) else $error("setting moved idle");
  chk_index_idle: assert property (csb_n_in[*8] |->
    $stable(status_word_index_out)) else $error("index moved idle");
  chk_oe_in_frame: assert property ((!csb_n_in)[*4] |-> so_oe_out)
    else $error("serial output not driven in frame");
  chk_oe_idle: assert property (csb_n_in[*5] |-> !so_oe_out)
    else $error("serial output driven while idle");
endmodule // hbs_ctrl_monitor
bind hbs_ctrl hbs_ctrl_monitor mon_u (.clock_in, .srst_in, .csb_n_in,
  .pwm_in, .so_oe_out, .channel_output_enable_out, .channel_drive_out,
  .channel_side_select_out, .channel_pwm_select_out, .pwm_source_field_out,
  .drive_supply_enable_out, .pump_switch_enable_out,
  .watchdog_timeout_select_out, .channel7_split_select_out,
  .status_word_index_out, .serial_fault_out);

/* bench/hbs_spi_host.sv */
`timescale 1ns/1ps
module hbs_spi_host (
  input  wire logic clock_in,
  input  wire logic so_in,
  output logic      sclk_out,
  output logic      csb_n_out,
  output logic      si_out
);
  initial begin
    sclk_out = 1'b0;
    csb_n_out = 1'b1;
    si_out = 1'b0;
  end
  // mode 1, 200 ns clock; sclk stands low outside frames
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    integer i;
    @(posedge clock_in) csb_n_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    for (i = 15; i >= 0; i--) begin
      sclk_out <= 1'b1;
      si_out <= w[i];
      repeat (4) @(posedge clock_in);
      r[i] = so_in;
      sclk_out <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
    csb_n_out <= 1'b1;
    // released line shows the inverse, not a held value
    si_out <= ~w[0];
    repeat (10) @(posedge clock_in);
  endtask
  // cut frame: n clock pulses only, zero pulses gives no edges at all
  task automatic cut(input int n);
    @(posedge clock_in) csb_n_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    repeat (n) begin
      sclk_out <= 1'b1;
      si_out <= 1'b0;
      repeat (4) @(posedge clock_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
    csb_n_out <= 1'b1;
    repeat (10) @(posedge clock_in);
  endtask
endmodule // hbs_spi_host

/* bench/test_halfbridge_spi_control_map.sv */
`timescale 1ns/1ps
module test_halfbridge_spi_control_map;
  localparam int WS = 600;
  localparam int WL = 1200;
  logic         clock_in, srst_in, sclk, csb_n, si, so, so_oe, tog;
  logic [3:0]   pwm_in;
  logic [127:0] sw;
  logic [6:0]   en, drv, side, sel;
  logic [13:0]  src;
  logic         dse, pse, wds, spl, flt;
  logic [2:0]   idx;
  logic [15:0]  rx;
  logic [14:0]  rw [6];
  logic [38:0]  re [6];
  logic [15:0]  bad [4];
  int           n_fail, compares, i;
  hbs_ctrl #(.WD_SHORT_CYC(WS), .WD_LONG_CYC(WL)) dut_u (.clock_in,
    .srst_in, .sclk_in(sclk), .csb_n_in(csb_n), .si_in(si), .pwm_in,
    .status_words_in(sw), .so_out(so), .so_oe_out(so_oe),
    .channel_output_enable_out(en), .channel_drive_out(drv),
    .channel_side_select_out(side), .channel_pwm_select_out(sel),
    .pwm_source_field_out(src), .drive_supply_enable_out(dse),
    .pump_switch_enable_out(pse), .watchdog_timeout_select_out(wds),
    .channel7_split_select_out(spl), .status_word_index_out(idx),
    .serial_fault_out(flt));
  hbs_spi_host host_u (.clock_in, .so_in(so), .sclk_out(sclk),
    .csb_n_out(csb_n), .si_out(si));
  function automatic logic [38:0] snap();
    return {en, side, sel, src, dse, pse, wds, spl};
  endfunction
  function automatic logic [15:0] swd(input int k);
    return 16'h1000 * k + 16'h03c5;
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] a, input logic [10:0] d);
    host_u.xfer({a, tog, d}, rx);
    tog = ~tog;
  endtask
  task automatic rst();
    @(posedge clock_in) srst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b0;
    tog = 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic tally_and_finish();
    $display("mismatches=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    srst_in = 1'b1;
    pwm_in = 4'h5;
    tog = 1'b0;
    n_fail = 0;
    compares = 0;
    for (i = 0; i < 8; i++) sw[i*16 +: 16] = swd(i);
    // enables written last: settings change only while tri-stated
    rw = '{15'h0fff, 15'h0e2a, 15'h1055, 15'h1be4, 15'h1c0e, 15'h007f};
    re = '{{7'h00, 7'h7f, 7'h00, 14'h0000, 4'hf},
           {7'h00, 7'h2a, 7'h00, 14'h0000, 4'hc},
           {7'h00, 7'h2a, 7'h55, 14'h0000, 4'hc},
           {7'h00, 7'h2a, 7'h55, 14'h03e4, 4'hc},
           {7'h00, 7'h2a, 7'h55, 14'h3be4, 4'hc},
           {7'h7f, 7'h2a, 7'h55, 14'h3be4, 4'hc}};
    bad = '{16'hd000, 16'h2080, 16'h3410, 16'h1c00};
    rst();
    chk({flt, snap()}, 40'h0);
    for (i = 0; i < 6; i++) begin
      cmd(rw[i][14:11], rw[i][10:0]);
      chk(snap(), re[i]);
    end
    chk({33'h0, drv}, 40'h2f);
    @(posedge clock_in) pwm_in <= 4'ha;
    cmd(4'h0, 11'h2ff);
    chk({30'h0, idx, drv}, {30'h0, 3'h5, 7'h7a});
    cmd(4'h4, 11'h000);
    chk({23'h0, rx}, {23'h0, swd(5)});
    cmd(4'h4, 11'h000);
    chk({23'h0, rx}, {23'h0, swd(0)});
    cmd(4'h0, 11'h7ff);
    cmd(4'h4, 11'h000);
    chk({23'h0, rx}, {23'h0, swd(7)});
    cmd(4'h4, 11'h000);
    chk({23'h0, rx}, {23'h0, swd(7)});
    chk({38'h0, flt}, 39'h0);
    repeat (WS + 50) @(posedge clock_in);
    chk({38'h0, flt}, 39'h1);
    chk({33'h0, drv}, 40'h0);
    rst();
    cmd(4'h1, 11'h100);
    repeat (WL - 300) @(posedge clock_in);
    chk({38'h0, flt}, 39'h0);
    repeat (400) @(posedge clock_in);
    chk({38'h0, flt}, 39'h1);
    for (i = 0; i < 4; i++) begin
      rst();
      host_u.xfer(bad[i], rx);
      chk({flt, snap()}, {1'b1, 39'h0});
    end
    // no clock edges at all, then a half-length frame
    for (i = 0; i < 2; i++) begin
      rst();
      host_u.cut(8 * i);
      chk({flt, snap()}, {1'b1, 39'h0});
    end
    tally_and_finish();
  end
endmodule // test_halfbridge_spi_control_map
